// ---- shared/mpcr_pkg.sv ----
package mpcr_pkg;
   // Register offsets inside the 256-byte register window
   localparam logic [7:0] OFS_BOOT_PROT = 8'hC2;
   localparam logic [7:0] OFS_PM_CTRL_A = 8'hB0;
   localparam logic [7:0] OFS_PM_CTRL_B = 8'hB4;
   localparam logic [7:0] OFS_PAGE = 8'hE0;
   localparam logic [7:0] OFS_SPACE_MAP = 8'hE2;
   localparam logic [7:0] OFS_MEM_SIZE_ID = 8'hF0;
   localparam logic [7:0] OFS_BOOT_SIZE_ID = 8'hF1;
   // Reset values
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] PM_RESET = 8'h00;
   localparam logic [7:0] MAP_RESET = 8'h00;
   // Power management A fields and writable mask
   localparam int PMA_AUTO_PD = 1;
   localparam int PMA_TURBO_OFF = 3;
   localparam int PMA_ARRAY_CLK_OFF = 4;
   localparam int PMA_MCELL_CLK_OFF = 5;
   localparam logic [7:0] PMA_USED = 8'h3A;
   // Power management B fields and writable mask
   localparam int PMB_ADDR_OFF = 0;
   localparam int PMB_CTL0_OFF = 2;
   localparam int PMB_ALE_OFF = 5;
   localparam int PMB_DBE_OFF = 6;
   localparam logic [7:0] PMB_USED = 8'h7D;
   // Space map fields
   localparam int MAP_SRAM_CODE = 0;
   localparam int MAP_BOOT_CODE = 1;
   localparam int MAP_MAIN_CODE = 2;
   localparam int MAP_BOOT_DATA = 3;
   localparam int MAP_MAIN_DATA = 4;
   localparam logic [7:0] MAP_USED = 8'h1F;
   // Identifier encodings
   localparam logic [3:0] MAIN_SIZE_2MBIT = 4'h4;
   localparam logic [3:0] MAIN_SIZE_8MBIT = 4'h5;
   localparam logic [3:0] SRAM_SIZE_NONE = 4'h0;
   localparam logic [3:0] SRAM_SIZE_16KBIT = 4'h1;
   localparam logic [3:0] SRAM_SIZE_64KBIT = 4'h3;
   localparam logic [3:0] BOOT_SIZE_NONE = 4'h0;
   localparam logic [3:0] BOOT_SIZE_256KBIT = 4'h2;
   localparam logic [1:0] BOOT_TYPE_FLASH = 2'h0;
   // Sector organisation and select product terms
   localparam int MAIN_SECTORS = 8;
   localparam int BOOT_SECTORS = 4;
   localparam int MAIN_SECTOR_KB = 64;
   localparam int BOOT_SECTOR_KB = 8;
   localparam int TERMS = 3;
   localparam int TERM_W = 13;
   localparam int TERM_EN = 12;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   typedef enum logic [1:0] {
      FST_IDLE = 2'b00,
      FST_ERASE = 2'b01,
      FST_SUSPEND = 2'b11,
      FST_PROGRAM = 2'b10
   } mpcr_flash_state_type;
endpackage : mpcr_pkg

// ---- design/mpcr_sector_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpcr_sector_decode
   import mpcr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Decode inputs
   input wire logic [3:0] addr_region,
   input wire logic [7:0] page_value,
   // Product term setup: enable, address region, page value per term
   input wire logic [MAIN_SECTORS*TERMS*TERM_W-1:0] main_term_cfg,
   input wire logic [BOOT_SECTORS*TERMS*TERM_W-1:0] boot_term_cfg,
   // Sector selects
   output logic [MAIN_SECTORS-1:0] main_sector_sel,
   output logic [BOOT_SECTORS-1:0] boot_sector_sel
);
   localparam int ALL = MAIN_SECTORS + BOOT_SECTORS;
   logic [ALL*TERMS*TERM_W-1:0] cfg_all;
   logic [ALL-1:0] sel_next;
   assign cfg_all = {boot_term_cfg, main_term_cfg};
   genvar s;
   generate
      for (s = 0; s < ALL; s++)
      begin : g_sector
         logic [TERMS-1:0] hit;
         for (genvar t = 0; t < TERMS; t++)
         begin : g_term
            logic [TERM_W-1:0] c;
            assign c = cfg_all[(s*TERMS+t)*TERM_W +: TERM_W];
            assign hit[t] = c[TERM_EN] && (c[11:8] == addr_region) && (c[7:0] == page_value);
         end
         // Several terms let one sector appear in more than one region
         assign sel_next[s] = |hit;
      end
   endgenerate
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         main_sector_sel <= '0;
         boot_sector_sel <= '0;
      end
      else
      begin
         main_sector_sel <= sel_next[MAIN_SECTORS-1:0];
         boot_sector_sel <= sel_next[ALL-1:MAIN_SECTORS];
      end
   end
endmodule : mpcr_sector_decode
`default_nettype wire

// ---- design/mpcr_flash_status.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpcr_flash_status
   import mpcr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Operation events from the instruction sequencer
   input wire logic prog_start,
   input wire logic prog_done,
   input wire logic erase_start,
   input wire logic erase_done,
   input wire logic suspend_req,
   input wire logic resume_req,
   input wire logic target_protected,
   // Status
   output logic op_busy,
   output logic erase_suspended,
   output logic op_refused
);
   mpcr_flash_state_type state_reg;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state_reg <= FST_IDLE;
      else
         case (state_reg)
            FST_IDLE:
               if (erase_start && !target_protected)
                  state_reg <= FST_ERASE;
               else if (prog_start && !target_protected)
                  state_reg <= FST_PROGRAM;
            FST_ERASE:
               if (erase_done)
                  state_reg <= FST_IDLE;
               else if (suspend_req)
                  state_reg <= FST_SUSPEND;
            FST_SUSPEND:
               if (resume_req)
                  state_reg <= FST_ERASE;
            FST_PROGRAM:
               if (prog_done)
                  state_reg <= FST_IDLE;
            default:
               state_reg <= FST_IDLE;
         endcase
   end
   // Protected sectors never start an operation; the refusal is flagged for one cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         op_refused <= 1'b0;
      else
         op_refused <= (state_reg == FST_IDLE) && (erase_start || prog_start) && target_protected;
   end
   // A suspended erase lets other sectors be read, so it counts as ready
   assign op_busy = (state_reg == FST_ERASE) || (state_reg == FST_PROGRAM);
   assign erase_suspended = (state_reg == FST_SUSPEND);
   a_suspend_hold: assert property (@(posedge clk) disable iff (!rstn)
      (state_reg == FST_SUSPEND && !resume_req) |=> (state_reg == FST_SUSPEND && !op_busy))
      else $error("suspended erase left without resume");
endmodule : mpcr_flash_status
`default_nettype wire

// ---- design/mpcr_regs.sv ----
// Summary of operation
// - Low four status bits show boot sector protection
// - Status top bit shows security lock set
// - Host page value feeds decode, resets zero
// - First power register resets zero; host writes zeros
// - Power A bit 1 enables automatic power-down
// - Power A bit 3 set turns fast mode off
// - Power A bit 4 clear routes clock, wakes array with fast mode off
// - Power A bit 5 set cuts macrocell clock
// - Power B bit 0 blocks low address bits
// - Power B bits 2-4 cut control inputs
// - Power B bits 5-6 cut strobe, enable; reset zero
// - Space map loads configuration on first clock after reset release, bit0 cleared
// - Map bits 0-2 gate fetch strobe access in extended host mode
// - Map bits 3-4 gate read strobe access in extended host mode
// - Size identifier encodes main flash, SRAM size
// - Boot identifier encodes boot size and type
// - Eight main, four boot sectors, each protectable
// - Sector erase can be suspended and resumed
// - Status pin can show program/erase progress
// - One select per sector from three terms
// - Registers sit at fixed window offsets
// - Status pin low while busy, high otherwise
`timescale 1ns/1ps
`default_nettype none
module mpcr_regs
   import mpcr_pkg::*;
#(
   // Identifier contents for this build
   parameter logic [3:0] MAIN_SIZE_CODE = MAIN_SIZE_2MBIT,
   parameter logic [3:0] SRAM_SIZE_CODE = SRAM_SIZE_64KBIT,
   parameter logic [3:0] BOOT_SIZE_CODE = BOOT_SIZE_256KBIT,
   parameter logic [1:0] BOOT_TYPE_CODE = BOOT_TYPE_FLASH
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Host register access
   input wire logic [15:0] bus_addr,
   input wire logic reg_window_select,
   input wire logic host_wr_en,
   input wire logic host_rd_en,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   // Host strobes and pins seen by the logic array
   input wire logic ext_host_mode,
   input wire logic [3:0] port_f_low_pins,
   input wire logic [3:0] addr_data_upper_pins,
   input wire logic ext_clock_in,
   input wire logic ctl_input_zero,
   input wire logic ctl_input_one,
   input wire logic ctl_input_two,
   input wire logic ale_in,
   input wire logic data_bus_enable_in,
   input wire logic prog_fetch_strobe_n,
   input wire logic rd_strobe_n,
   // User configuration
   input wire logic [4:1] space_map_cfg,
   input wire logic [BOOT_SECTORS-1:0] boot_sector_protect,
   input wire logic [MAIN_SECTORS-1:0] main_sector_protect,
   input wire logic security_set,
   input wire logic status_pin_cfg,
   input wire logic [MAIN_SECTORS*TERMS*TERM_W-1:0] main_term_cfg,
   input wire logic [BOOT_SECTORS*TERMS*TERM_W-1:0] boot_term_cfg,
   // Flash operation events
   input wire logic prog_start,
   input wire logic prog_done,
   input wire logic erase_start,
   input wire logic erase_done,
   input wire logic suspend_req,
   input wire logic resume_req,
   // Outputs to the decode array
   output logic [7:0] page_out,
   output logic [7:0] array_addr_low,
   output logic [2:0] array_ctl,
   output logic array_ale,
   output logic array_dbe,
   output logic array_clk,
   output logic mcell_clk,
   output logic turbo_on,
   output logic auto_power_down,
   output logic array_wake,
   // Memory access permissions and selects
   output logic sram_in_code_space,
   output logic boot_in_code_space,
   output logic main_in_code_space,
   output logic boot_in_data_space,
   output logic main_in_data_space,
   output logic [MAIN_SECTORS-1:0] main_sector_sel,
   output logic [BOOT_SECTORS-1:0] boot_sector_sel,
   // Flash status
   output logic erase_suspended,
   output logic op_refused,
   output logic status_pin_out,
   output logic status_pin_oe
);
   logic [7:0] page_select_reg;
   logic [7:0] power_mgmt_ctrl_a_reg;
   logic [7:0] power_mgmt_ctrl_b_reg;
   logic [7:0] space_map_reg;
   logic map_load_reg;
   logic clk_in_reg;
   logic clk_hist_reg;
   logic [7:0] rdata_next;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] ofs;
   logic [3:0] addr_region;
   logic [7:0] addr_low_src;
   logic op_busy;
   logic protected_target;
   logic [7:0] boot_protect_status;
   logic [7:0] memory_size_ident;
   logic [7:0] boot_size_ident;

   assign ofs = bus_addr[7:0];
   assign wr_hit = reg_window_select && host_wr_en;
   assign rd_hit = reg_window_select && host_rd_en;
   assign boot_protect_status = {security_set, 3'h0, boot_sector_protect};
   assign memory_size_ident = {SRAM_SIZE_CODE, MAIN_SIZE_CODE};
   assign boot_size_ident = {2'h0, BOOT_TYPE_CODE, BOOT_SIZE_CODE};

   // Page register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         page_select_reg <= PAGE_RESET;
      else if (wr_hit && ofs == OFS_PAGE)
         page_select_reg <= host_wdata;
   end

   // Power management registers; unused positions are kept at zero
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         power_mgmt_ctrl_a_reg <= PM_RESET;
         power_mgmt_ctrl_b_reg <= PM_RESET;
      end
      else if (wr_hit)
      begin
         if (ofs == OFS_PM_CTRL_A)
            power_mgmt_ctrl_a_reg <= host_wdata & PMA_USED;
         else if (ofs == OFS_PM_CTRL_B)
            power_mgmt_ctrl_b_reg <= host_wdata & PMB_USED;
      end
   end

   // Space map: configuration is caught on the first edge after reset release,
   // because an asynchronous reset may only load constants
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         space_map_reg <= MAP_RESET;
         map_load_reg <= 1'b1;
      end
      else if (map_load_reg)
      begin
         space_map_reg <= {3'h0, space_map_cfg, 1'b0};
         map_load_reg <= 1'b0;
      end
      else if (wr_hit && ofs == OFS_SPACE_MAP)
         space_map_reg <= host_wdata & MAP_USED;
   end

   // Read path; the read-only registers have no write branch at all
   always_comb
   begin
      rdata_next = UNMAPPED_DATA;
      if (ofs == OFS_BOOT_PROT)
         rdata_next = boot_protect_status;
      else if (ofs == OFS_PM_CTRL_A)
         rdata_next = power_mgmt_ctrl_a_reg;
      else if (ofs == OFS_PM_CTRL_B)
         rdata_next = power_mgmt_ctrl_b_reg;
      else if (ofs == OFS_PAGE)
         rdata_next = page_select_reg;
      else if (ofs == OFS_SPACE_MAP)
         rdata_next = space_map_reg;
      else if (ofs == OFS_MEM_SIZE_ID)
         rdata_next = memory_size_ident;
      else if (ofs == OFS_BOOT_SIZE_ID)
         rdata_next = boot_size_ident;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         host_rdata <= UNMAPPED_DATA;
      else if (rd_hit)
         host_rdata <= rdata_next;
   end

   // Gated inputs to the logic array
   assign addr_low_src = ext_host_mode ? {addr_data_upper_pins, port_f_low_pins} : bus_addr[7:0];
   assign array_addr_low = power_mgmt_ctrl_b_reg[PMB_ADDR_OFF] ? 8'h00 : addr_low_src;
   assign array_ctl = {ctl_input_two, ctl_input_one, ctl_input_zero} &
                      ~power_mgmt_ctrl_b_reg[PMB_CTL0_OFF +: 3];
   assign array_ale = ale_in && !power_mgmt_ctrl_b_reg[PMB_ALE_OFF];
   assign array_dbe = data_bus_enable_in && !power_mgmt_ctrl_b_reg[PMB_DBE_OFF];
   assign array_clk = ext_clock_in && !power_mgmt_ctrl_a_reg[PMA_ARRAY_CLK_OFF];
   assign mcell_clk = ext_clock_in && !power_mgmt_ctrl_a_reg[PMA_MCELL_CLK_OFF];
   assign turbo_on = !power_mgmt_ctrl_a_reg[PMA_TURBO_OFF];
   assign auto_power_down = power_mgmt_ctrl_a_reg[PMA_AUTO_PD];
   assign page_out = page_select_reg;

   // Clock wake-up: only a connected clock may wake a non-turbo array
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         clk_in_reg <= 1'b0;
         clk_hist_reg <= 1'b0;
         array_wake <= 1'b0;
      end
      else
      begin
         clk_in_reg <= ext_clock_in;
         // The first sample after reset has no history to compare with
         clk_hist_reg <= 1'b1;
         array_wake <= (ext_clock_in != clk_in_reg) && clk_hist_reg && !turbo_on &&
                       !power_mgmt_ctrl_a_reg[PMA_ARRAY_CLK_OFF];
      end
   end

   // Space permissions apply only in extended host mode; otherwise all open
   always_comb
   begin
      sram_in_code_space = 1'b1;
      boot_in_code_space = 1'b1;
      main_in_code_space = 1'b1;
      boot_in_data_space = 1'b1;
      main_in_data_space = 1'b1;
      if (ext_host_mode)
      begin
         sram_in_code_space = space_map_reg[MAP_SRAM_CODE] && !prog_fetch_strobe_n;
         boot_in_code_space = space_map_reg[MAP_BOOT_CODE] && !prog_fetch_strobe_n;
         main_in_code_space = space_map_reg[MAP_MAIN_CODE] && !prog_fetch_strobe_n;
         boot_in_data_space = space_map_reg[MAP_BOOT_DATA] && !rd_strobe_n;
         main_in_data_space = space_map_reg[MAP_MAIN_DATA] && !rd_strobe_n;
      end
   end

   assign addr_region = bus_addr[15:12];

   mpcr_sector_decode u_decode (
      .clk(clk),
      .rstn(rstn),
      .addr_region(addr_region),
      .page_value(page_select_reg),
      .main_term_cfg(main_term_cfg),
      .boot_term_cfg(boot_term_cfg),
      .main_sector_sel(main_sector_sel),
      .boot_sector_sel(boot_sector_sel)
   );

   // The operation targets whichever selected sector is protected
   assign protected_target = |(main_sector_sel & main_sector_protect) ||
                             |(boot_sector_sel & boot_sector_protect);

   mpcr_flash_status u_status (
      .clk(clk),
      .rstn(rstn),
      .prog_start(prog_start),
      .prog_done(prog_done),
      .erase_start(erase_start),
      .erase_done(erase_done),
      .suspend_req(suspend_req),
      .resume_req(resume_req),
      .target_protected(protected_target),
      .op_busy(op_busy),
      .erase_suspended(erase_suspended),
      .op_refused(op_refused)
   );

   // Status pin: low while busy
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         status_pin_out <= 1'b1;
         status_pin_oe <= 1'b0;
      end
      else
      begin
         status_pin_out <= !op_busy;
         status_pin_oe <= status_pin_cfg;
      end
   end

   a_page_write: assert property (@(posedge clk) disable iff (!rstn)
      (wr_hit && ofs == OFS_PAGE) |=> (page_out == $past(host_wdata)))
      else $error("page value not taken from write");

   a_apd_enable: assert property (@(posedge clk) disable iff (!rstn)
      (wr_hit && ofs == OFS_PM_CTRL_A) |=> (auto_power_down == $past(host_wdata[1])))
      else $error("power-down enable does not follow write");

   a_turbo_write: assert property (@(posedge clk) disable iff (!rstn)
      (wr_hit && ofs == OFS_PM_CTRL_A) |=> (turbo_on != $past(host_wdata[3])))
      else $error("fast mode does not follow write");

   a_wake_pulse: assert property (@(posedge clk) disable iff (!rstn)
      ($past(rstn) && ext_clock_in != $past(ext_clock_in) && !turbo_on &&
         !power_mgmt_ctrl_a_reg[PMA_ARRAY_CLK_OFF]) |=> array_wake)
      else $error("clock change did not wake array");

   a_mcell_cut: assert property (@(posedge clk) disable iff (!rstn)
      (wr_hit && ofs == OFS_PM_CTRL_A && host_wdata[5]) |=> !mcell_clk)
      else $error("macrocell clock not cut");

   a_addr_block: assert property (@(posedge clk) disable iff (!rstn)
      power_mgmt_ctrl_b_reg[0] |-> (array_addr_low == 8'h00))
      else $error("low address reached array while blocked");

   a_ctl_cut: assert property (@(posedge clk) disable iff (!rstn)
      (wr_hit && ofs == OFS_PM_CTRL_B && host_wdata[4:2] == 3'h7) |=> (array_ctl == 3'h0))
      else $error("control inputs not cut");

   a_strobe_cut: assert property (@(posedge clk) disable iff (!rstn)
      (wr_hit && ofs == OFS_PM_CTRL_B && host_wdata[6:5] == 2'h3) |=> (!array_ale && !array_dbe))
      else $error("strobe or enable not cut");

   a_map_load: assert property (@(posedge clk) disable iff (!rstn)
      map_load_reg |=> (space_map_reg == {3'h0, $past(space_map_cfg), 1'b0}))
      else $error("space map not loaded after reset");

   a_fetch_gate: assert property (@(posedge clk) disable iff (!rstn)
      (ext_host_mode && !space_map_reg[2]) |-> !main_in_code_space)
      else $error("fetch reached blocked main flash");

   a_read_gate: assert property (@(posedge clk) disable iff (!rstn)
      (ext_host_mode && !space_map_reg[3]) |-> !boot_in_data_space)
      else $error("read reached blocked boot flash");

   a_boot_status: assert property (@(posedge clk) disable iff (!rstn)
      (rd_hit && ofs == OFS_BOOT_PROT) |=>
         (host_rdata == {$past(security_set), 3'h0, $past(boot_sector_protect)}))
      else $error("boot protection status read wrong");

   a_busy_pin: assert property (@(posedge clk) disable iff (!rstn)
      op_busy |=> !status_pin_out)
      else $error("status pin high during operation");
endmodule : mpcr_regs
`default_nettype wire

// ---- dv/mpcr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mpcr_host_model
(
   // Clock
   input wire logic clk,
   // Register bus, driven as the host
   output logic [15:0] bus_addr,
   output logic reg_window_select,
   output logic host_wr_en,
   output logic host_rd_en,
   output logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata
);
   initial
   begin
      bus_addr = 16'h0000;
      reg_window_select = 1'b0;
      host_wr_en = 1'b0;
      host_rd_en = 1'b0;
      host_wdata = 8'h00;
   end

   // The address stays put after a cycle, so the decode array keeps seeing it
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      bus_addr = a;
      host_wdata = d;
      reg_window_select = 1'b1;
      host_wr_en = 1'b1;
      @(posedge clk);
      #1;
      reg_window_select = 1'b0;
      host_wr_en = 1'b0;
      // Released data shows the inverse so a stale byte cannot pass
      host_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      bus_addr = a;
      reg_window_select = 1'b1;
      host_rd_en = 1'b1;
      @(posedge clk);
      #1;
      reg_window_select = 1'b0;
      host_rd_en = 1'b0;
      @(posedge clk);
      #1;
      d = host_rdata;
   endtask : rd
endmodule : mpcr_host_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
   import mpcr_pkg::*;
;
   logic clk, rstn, ext_host_mode, ext_clock_in, ctl_input_zero, ctl_input_one, ctl_input_two;
   logic ale_in, data_bus_enable_in, prog_fetch_strobe_n, rd_strobe_n, security_set, status_pin_cfg;
   logic prog_start, prog_done, erase_start, erase_done, suspend_req, resume_req;
   logic reg_window_select, host_wr_en, host_rd_en, array_ale, array_dbe, array_clk, mcell_clk;
   logic turbo_on, auto_power_down, array_wake, erase_suspended, op_refused, status_pin_out, status_pin_oe;
   logic sram_in_code_space, boot_in_code_space, main_in_code_space, boot_in_data_space, main_in_data_space;
   logic wake_seen, refused_seen;
   logic [15:0] bus_addr;
   logic [7:0] host_wdata, host_rdata, page_out, array_addr_low;
   logic [3:0] port_f_low_pins, addr_data_upper_pins, space_map_cfg, boot_sector_protect, boot_sector_sel;
   logic [MAIN_SECTORS-1:0] main_sector_protect, main_sector_sel;
   logic [MAIN_SECTORS*TERMS*TERM_W-1:0] main_term_cfg;
   logic [BOOT_SECTORS*TERMS*TERM_W-1:0] boot_term_cfg;
   logic [2:0] array_ctl;
   int bad_count, check_count, cyc;

   mpcr_host_model hu (.clk, .bus_addr, .reg_window_select, .host_wr_en, .host_rd_en, .host_wdata, .host_rdata);
   mpcr_regs dut_u (.clk, .rstn, .bus_addr, .reg_window_select, .host_wr_en, .host_rd_en, .host_wdata,
      .host_rdata, .ext_host_mode, .port_f_low_pins, .addr_data_upper_pins, .ext_clock_in, .ctl_input_zero,
      .ctl_input_one, .ctl_input_two, .ale_in, .data_bus_enable_in, .prog_fetch_strobe_n, .rd_strobe_n,
      .space_map_cfg, .boot_sector_protect, .main_sector_protect, .security_set, .status_pin_cfg,
      .main_term_cfg, .boot_term_cfg, .prog_start, .prog_done, .erase_start, .erase_done, .suspend_req,
      .resume_req, .page_out, .array_addr_low, .array_ctl, .array_ale, .array_dbe, .array_clk, .mcell_clk,
      .turbo_on, .auto_power_down, .array_wake, .sram_in_code_space, .boot_in_code_space, .main_in_code_space,
      .boot_in_data_space, .main_in_data_space, .main_sector_sel, .boot_sector_sel, .erase_suspended,
      .op_refused, .status_pin_out, .status_pin_oe);

   always #5 clk = ~clk;

   // Pulses last one cycle, so they are caught here rather than polled
   always @(posedge clk)
   begin
      cyc++;
      if (array_wake === 1'b1)
         wake_seen <= 1'b1;
      if (op_refused === 1'b1)
         refused_seen <= 1'b1;
      if (cyc == 3000)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic chb(input string n, input logic e, input logic g);
      chk(n, {7'h00, e}, {7'h00, g});
   endtask : chb

   task automatic rchk(input logic [7:0] o, input logic [7:0] e);
      logic [7:0] d;
      hu.rd({8'h00, o}, d);
      chk($sformatf("register %h", o), e, d);
   endtask : rchk

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic t_regs;
      rchk(8'hB0, 8'h00);
      rchk(8'hB4, 8'h00);
      rchk(8'hE0, 8'h00);
      rchk(8'hE2, 8'h14);
      rchk(8'hC2, 8'h85);
      rchk(8'hF0, 8'h34);
      rchk(8'hF1, 8'h02);
      rchk(8'h7F, 8'h00);
      hu.wr(16'h00C2, 8'h7A);
      hu.wr(16'h00F0, 8'hFF);
      hu.wr(16'h00F1, 8'hFF);
      rchk(8'hC2, 8'h85);
      rchk(8'hF0, 8'h34);
      rchk(8'hF1, 8'h02);
      hu.wr(16'h00E0, 8'hA5);
      chk("page out", 8'hA5, page_out);
      rchk(8'hE0, 8'hA5);
      $display("Test registers done");
   endtask : t_regs

   task automatic t_power;
      {ctl_input_zero, ctl_input_one, ctl_input_two, ale_in, data_bus_enable_in, ext_clock_in} = 6'h3F;
      hu.wr(16'h00B0, 8'hFF);
      rchk(8'hB0, 8'h3A);
      chk("pm a outputs", 8'h08, {auto_power_down, turbo_on, array_clk, mcell_clk});
      hu.wr(16'h00B4, 8'hFF);
      rchk(8'hB4, 8'h7D);
      chk("low addr blocked", 8'h00, array_addr_low);
      chk("ctl blocked", 8'h00, {array_ctl, array_ale, array_dbe});
      hu.wr(16'h00B0, 8'h00);
      chk("pm a cleared", 8'h07, {auto_power_down, turbo_on, array_clk, mcell_clk});
      hu.wr(16'h00B4, 8'h00);
      chk("low addr", 8'hB4, array_addr_low);
      chk("ctl passed", 8'h1F, {array_ctl, array_ale, array_dbe});
      hu.wr(16'h00B0, 8'h08);
      wake_seen = 1'b0;
      repeat (3)
      begin
         ext_clock_in = ~ext_clock_in;
         step(3);
      end
      chb("array clk", ext_clock_in, array_clk);
      chb("wake", 1'b1, wake_seen);
      hu.wr(16'h00B0, 8'h18);
      ext_clock_in = 1'b1;
      step(2);
      wake_seen = 1'b0;
      ext_clock_in = 1'b0;
      step(3);
      ext_clock_in = 1'b1;
      step(3);
      chb("array clk cut", 1'b0, array_clk);
      chb("no wake", 1'b0, wake_seen);
      ext_host_mode = 1'b1;
      #1;
      chk("ext low addr", 8'h3C, array_addr_low);
      $display("Test power done");
   endtask : t_power

   task automatic t_map;
      {prog_fetch_strobe_n, rd_strobe_n} = 2'b00;
      for (int i = 0; i < 5; i++)
      begin
         hu.wr(16'h00E2, 8'h01 << i);
         chk("space map", 8'h01 << i, {3'h0, main_in_data_space, boot_in_data_space, main_in_code_space,
            boot_in_code_space, sram_in_code_space});
      end
      hu.wr(16'h00E2, 8'hFF);
      rchk(8'hE2, 8'h1F);
      {prog_fetch_strobe_n, rd_strobe_n} = 2'b11;
      #1;
      chk("no strobe", 8'h00, {3'h0, main_in_data_space, boot_in_data_space, main_in_code_space,
         boot_in_code_space, sram_in_code_space});
      $display("Test space map done");
   endtask : t_map

   task automatic t_flash;
      erase_start = 1'b1;
      step(1);
      erase_start = 1'b0;
      step(2);
      chk("erase busy", 8'h01, {status_pin_out, status_pin_oe});
      suspend_req = 1'b1;
      step(1);
      suspend_req = 1'b0;
      step(2);
      chk("suspended", 8'h03, {erase_suspended, status_pin_out});
      resume_req = 1'b1;
      step(1);
      resume_req = 1'b0;
      step(2);
      chk("resumed", 8'h00, {erase_suspended, status_pin_out});
      erase_done = 1'b1;
      step(1);
      erase_done = 1'b0;
      step(2);
      chb("erase ready", 1'b1, status_pin_out);
      prog_start = 1'b1;
      step(1);
      prog_start = 1'b0;
      step(2);
      chb("prog busy", 1'b0, status_pin_out);
      prog_done = 1'b1;
      step(1);
      prog_done = 1'b0;
      step(2);
      chb("prog ready", 1'b1, status_pin_out);
      $display("Test flash status done");
   endtask : t_flash

   task automatic t_decode;
      main_sector_protect = 8'h01;
      main_term_cfg[12:0] = 13'h1207;
      boot_term_cfg[12:0] = 13'h1207;
      hu.wr(16'h20E0, 8'h07);
      step(2);
      chk("sector sel", 8'h01, main_sector_sel);
      chk("boot sel", 8'h01, {4'h0, boot_sector_sel});
      prog_start = 1'b1;
      step(1);
      prog_start = 1'b0;
      step(3);
      chk("refused", 8'h03, {refused_seen, status_pin_out});
      $display("Test decode done");
   endtask : t_decode

   initial
   begin
      {clk, rstn, ext_host_mode, ext_clock_in, ctl_input_zero, ctl_input_one, ctl_input_two} = 7'h00;
      {ale_in, data_bus_enable_in, prog_fetch_strobe_n, rd_strobe_n} = 4'h3;
      {prog_start, prog_done, erase_start, erase_done, suspend_req, resume_req} = 6'h00;
      {port_f_low_pins, addr_data_upper_pins, wake_seen, refused_seen} = 10'h0C3 << 2;
      {security_set, status_pin_cfg, space_map_cfg, boot_sector_protect} = 10'h3A5;
      main_sector_protect = 8'h00;
      main_term_cfg = '0;
      boot_term_cfg = '0;
      bad_count = 0;
      check_count = 0;
      cyc = 0;
      step(20);
      rstn = 1'b1;
      step(2);
      t_regs();
      t_power();
      t_map();
      t_flash();
      t_decode();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
